// File: design/vsfp_pkg.sv
// Package of register map, field layout and constants for the field parameters
package vsfp_pkg;
  // Serial frame: address then data, least significant bit first
  localparam int ADDR_BITS = 8;
  localparam int DATA_BITS = 26;
  localparam int FRAME_BITS = ADDR_BITS + DATA_BITS;
  localparam int POS_BITS = 13;
  localparam int NUM_REGS = 13;
  localparam int NUM_VCLK = 13;

  // Register addresses
  localparam logic [7:0] GROUP_A_REPEAT_3_4 = 8'h07;
  localparam logic [7:0] VERTICAL_HOLD_POINT_1 = 8'h08;
  localparam logic [7:0] VERTICAL_HOLD_POINT_2 = 8'h09;
  localparam logic [7:0] EVEN_BLANK_TOGGLE_1_2 = 8'h0A;
  localparam logic [7:0] EVEN_BLANK_TOGGLE_3_4 = 8'h0B;
  localparam logic [7:0] BLANK_REGION_BOUNDS = 8'h0C;
  localparam logic [7:0] BLANK_LENGTH_REPEAT_MASK = 8'h0D;
  localparam logic [7:0] CLAMP_TOGGLE_POINTS = 8'h0E;
  localparam logic [7:0] PREBLANK_TOGGLE_POINTS = 8'h0F;
  localparam logic [7:0] RESERVED_10 = 8'h10;
  localparam logic [7:0] SPECIAL_PATTERN_CONTROL = 8'h11;
  localparam logic [7:0] RESERVED_12 = 8'h12;
  localparam logic [7:0] RESERVED_13 = 8'h13;

  // Field positions
  localparam int LOW_FIELD_LSB = 0;
  localparam int HIGH_FIELD_LSB = 13;
  localparam int REPEAT_COUNT_LSB = 13;
  localparam int REPEAT_COUNT_BITS = 8;
  localparam int CLOCK_ONE_MASK_BIT = 21;
  localparam int CLOCK_THREE_MASK_BIT = 22;
  localparam int LAST_STAGE_MASK_BIT = 23;
  localparam int SPECIAL_LINE_BITS = 12;
  localparam int SPECIAL_ENABLE_BIT = 13;

  // Reset value of every stored register (undefined on the part, zero here)
  localparam logic [25:0] REG_RESET = 26'h0000000;

  // Mode thresholds
  localparam logic [2:0] BLANK_PULSE_MODE_MIN = 3'h4;
  localparam logic [1:0] ALT_THIRD_LINE_MODE = 2'h2;
  localparam logic [1:0] ALT_FOURTH_LINE_MODE = 2'h3;

  typedef enum logic [1:0] {
    VSFP_SER_IDLE = 2'b01,
    VSFP_SER_SHIFT = 2'b10
  } vsfp_ser_state_t;
endpackage

// File: design/vsfp_field_params.sv
// Field parameter registers and the per-line timing they steer
// Notes on behaviour
// R01 - Register 07 low field: third-line repeat count, else odd toggle one.
// R02 - Register 07 high field: fourth-line repeat count, else odd toggle two.
// R03 - At a hold point all thirteen vertical clocks keep their present levels; on the special active line the special pattern drives them instead.
// R04 - At the matching restart point the held vertical clocks run on again.
// R05 - Without hold use, hold/restart fields are odd toggles three to six.
// R06 - Registers 0A and 0B give even-line blanking toggles one to four.
// R07 - Modes 4-7 use start/end as blanking region; else even toggles five, six.
// R08 - Modes 4-7 make blanking pulses of set length, repeated by 8-bit count.
// R09 - During blanking, clocks one, three and last stage go to mask levels.
// R10 - The clamp pulse toggles at two programmed line positions.
// R11 - The pre-blanking pulse toggles at two programmed line positions.
// R12 - When enabled, the special vertical pattern is output on its active line.
// R13 - Software writes zero to unused bits and to the unused registers.
// R14 - Alternation mode 0 uses first count always; 1-3 give 2-4 line cycling.
// R15 - Written values take effect only at the sequence change update point.
module vsfp_field_params (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Three-wire serial port, asynchronous to i_clock
  input wire logic i_serial_clock,
  input wire logic i_serial_data,
  input wire logic i_serial_load,
  // Line timing from the timing core
  input wire logic i_line_start,
  input wire logic [12:0] i_line_position,
  input wire logic [11:0] i_line_number,
  input wire logic i_line_odd,
  input wire logic i_sequence_change_update,
  // Settings held in neighbouring registers
  input wire logic [1:0] i_group_a_alternation_mode,
  input wire logic [2:0] i_blank_alternation_mode,
  input wire logic i_hold_enable,
  input wire logic [11:0] i_group_a_first_line_repeats,
  input wire logic [11:0] i_group_a_second_line_repeats,
  // Pattern sources
  input wire logic [12:0] i_vertical_pattern,
  input wire logic [12:0] i_special_pattern,
  input wire logic i_horiz_clock_one,
  input wire logic i_horiz_clock_three,
  input wire logic i_horiz_last_stage_clock,
  // Outputs to the drivers
  output logic [12:0] o_vertical_clock_out,
  output logic o_horizontal_blanking,
  output logic o_horiz_clock_one,
  output logic o_horiz_clock_three,
  output logic o_horiz_last_stage_clock,
  output logic o_optical_black_clamp,
  output logic o_pre_blanking_pulse,
  output logic [12:0] o_group_a_repeats,
  output logic o_vertical_held,
  output logic o_special_pattern_active
);

  typedef struct packed {
    logic [1:0] sclk_sync;
    logic [1:0] sdata_sync;
    logic [1:0] sload_sync;
    logic sclk_last;
    vsfp_pkg::vsfp_ser_state_t ser_state;
    logic [vsfp_pkg::FRAME_BITS-1:0] shifter;
    logic [5:0] bit_count;
    logic [vsfp_pkg::NUM_REGS-1:0][25:0] staged;
    logic [vsfp_pkg::NUM_REGS-1:0][25:0] active;
    logic [1:0] line_type;
    logic held;
    logic [12:0] vclk;
    logic blank;
    logic [12:0] pulse_count;
    logic [7:0] pulses_left;
    logic in_region;
    logic clamp;
    logic preblank;
    logic special;
    logic [12:0] repeats;
    logic h1;
    logic h3;
    logic hl;
  } vsfp_state_t;
  vsfp_state_t state, next_state;
  function automatic logic [12:0] low_field(input logic [25:0] word);
    low_field = word[vsfp_pkg::LOW_FIELD_LSB +: vsfp_pkg::POS_BITS];
  endfunction
  function automatic logic [12:0] high_field(input logic [25:0] word);
    high_field = word[vsfp_pkg::HIGH_FIELD_LSB +: vsfp_pkg::POS_BITS];
  endfunction
  function automatic logic [3:0] reg_index(input logic [7:0] addr);
    logic [7:0] diff;
    diff = addr - vsfp_pkg::GROUP_A_REPEAT_3_4;
    reg_index = diff[3:0];
  endfunction
  function automatic logic in_map(input logic [7:0] addr);
    in_map = (addr >= vsfp_pkg::GROUP_A_REPEAT_3_4)
      && (addr <= vsfp_pkg::RESERVED_13);
  endfunction
  // Active register words
  logic [25:0] w_rep34, w_hold1, w_hold2, w_even12, w_even34, w_bounds;
  logic [25:0] w_len, w_clamp, w_preblank, w_special;
  always_comb
  begin
    w_rep34 = state.active[reg_index(vsfp_pkg::GROUP_A_REPEAT_3_4)];
    w_hold1 = state.active[reg_index(vsfp_pkg::VERTICAL_HOLD_POINT_1)];
    w_hold2 = state.active[reg_index(vsfp_pkg::VERTICAL_HOLD_POINT_2)];
    w_even12 = state.active[reg_index(vsfp_pkg::EVEN_BLANK_TOGGLE_1_2)];
    w_even34 = state.active[reg_index(vsfp_pkg::EVEN_BLANK_TOGGLE_3_4)];
    w_bounds = state.active[reg_index(vsfp_pkg::BLANK_REGION_BOUNDS)];
    w_len = state.active[reg_index(vsfp_pkg::BLANK_LENGTH_REPEAT_MASK)];
    w_clamp = state.active[reg_index(vsfp_pkg::CLAMP_TOGGLE_POINTS)];
    w_preblank = state.active[reg_index(vsfp_pkg::PREBLANK_TOGGLE_POINTS)];
    w_special = state.active[reg_index(vsfp_pkg::SPECIAL_PATTERN_CONTROL)];
  end
  // Toggle table for the current line; unused slots stay disabled
  logic [5:0][12:0] toggle_pos;
  logic [5:0] toggle_use;
  logic pulse_mode;
  always_comb
  begin
    pulse_mode = i_blank_alternation_mode >= vsfp_pkg::BLANK_PULSE_MODE_MIN;
    toggle_pos = '0;
    toggle_use = '0;
    if (i_line_odd)
    begin
      toggle_pos[0] = low_field(w_rep34);
      toggle_pos[1] = high_field(w_rep34);
      toggle_pos[2] = low_field(w_hold1);
      toggle_pos[3] = high_field(w_hold1);
      toggle_pos[4] = low_field(w_hold2);
      toggle_pos[5] = high_field(w_hold2);
      // Repeat counts own these fields once that line type is cycled
      toggle_use[0] = i_group_a_alternation_mode
        < vsfp_pkg::ALT_THIRD_LINE_MODE; // R01
      toggle_use[1] = i_group_a_alternation_mode
        < vsfp_pkg::ALT_FOURTH_LINE_MODE; // R02
      toggle_use[5:2] = {4{~i_hold_enable}}; // R05
    end
    else
    begin
      toggle_pos[0] = low_field(w_even12); // R06
      toggle_pos[1] = high_field(w_even12); // R06
      toggle_pos[2] = low_field(w_even34); // R06
      toggle_pos[3] = high_field(w_even34); // R06
      toggle_pos[4] = low_field(w_bounds);
      toggle_pos[5] = high_field(w_bounds);
      toggle_use[3:0] = 4'hF;
      toggle_use[5:4] = {2{~pulse_mode}}; // R07
    end
  end

  logic [5:0] toggle_hit;
  genvar g;
  generate
    for (g = 0; g < 6; g++)
    begin : gen_toggle
      assign toggle_hit[g] = toggle_use[g]
        && (i_line_position == toggle_pos[g]);
    end
  endgenerate
  logic [12:0] pulse_len;
  logic [7:0] pulse_reps;
  logic hold_hit, restart_hit;
  logic [25:0] frame_data;
  logic [7:0] frame_addr;
  always_comb
  begin
    pulse_len = low_field(w_len);
    pulse_reps = w_len[vsfp_pkg::REPEAT_COUNT_LSB +:
      vsfp_pkg::REPEAT_COUNT_BITS];
    hold_hit = i_hold_enable
      && ((i_line_position == low_field(w_hold1))
      || (i_line_position == low_field(w_hold2)));
    restart_hit = i_hold_enable
      && ((i_line_position == high_field(w_hold1))
      || (i_line_position == high_field(w_hold2)));
    frame_addr = state.shifter[vsfp_pkg::ADDR_BITS-1:0];
    frame_data = state.shifter[vsfp_pkg::FRAME_BITS-1:vsfp_pkg::ADDR_BITS];
  end
  always_comb
  begin
    next_state = state;
    // Serial pins pass two flops before anything reads them
    next_state.sclk_sync = {state.sclk_sync[0], i_serial_clock};
    next_state.sdata_sync = {state.sdata_sync[0], i_serial_data};
    next_state.sload_sync = {state.sload_sync[0], i_serial_load};
    next_state.sclk_last = state.sclk_sync[1];
    case (state.ser_state)
      vsfp_pkg::VSFP_SER_IDLE:
      begin
        if (!state.sload_sync[1])
        begin
          next_state.ser_state = vsfp_pkg::VSFP_SER_SHIFT;
          next_state.bit_count = 6'h00;
        end
      end
      vsfp_pkg::VSFP_SER_SHIFT:
      begin
        if (state.sclk_sync[1] && !state.sclk_last
          && !state.sload_sync[1])
        begin
          next_state.shifter = {state.sdata_sync[1],
            state.shifter[vsfp_pkg::FRAME_BITS-1:1]};
          if (state.bit_count != 6'h3F)
            next_state.bit_count = state.bit_count + 6'h01;
        end
        if (state.sload_sync[1])
        begin
          next_state.ser_state = vsfp_pkg::VSFP_SER_IDLE;
          // Short or over-long frames are dropped, not half written
          if ((state.bit_count == 6'(vsfp_pkg::FRAME_BITS))
            && in_map(frame_addr))
            next_state.staged[reg_index(frame_addr)] = frame_data;
        end
      end
      default:
        next_state.ser_state = vsfp_pkg::VSFP_SER_IDLE;
    endcase
    if (i_sequence_change_update)
      next_state.active = next_state.staged; // R15

    // Line type cycle for Group A repeat counts
    if (i_line_start)
    begin
      if (state.line_type >= i_group_a_alternation_mode)
        next_state.line_type = 2'h0; // R14
      else
        next_state.line_type = state.line_type + 2'h1; // R14
    end
    case (state.line_type)
      2'h0: next_state.repeats = {1'b0, i_group_a_first_line_repeats};
      2'h1: next_state.repeats = {1'b0, i_group_a_second_line_repeats};
      2'h2: next_state.repeats = low_field(w_rep34); // R01
      default: next_state.repeats = high_field(w_rep34); // R02
    endcase

    // Hold and restart of the vertical clocks
    if (restart_hit)
      next_state.held = 1'b0; // R04
    else if (hold_hit)
      next_state.held = 1'b1; // R03
    if (!next_state.held)
      next_state.vclk = i_vertical_pattern; // R03
    next_state.special = w_special[vsfp_pkg::SPECIAL_ENABLE_BIT]
      && (i_line_number
      == w_special[vsfp_pkg::SPECIAL_LINE_BITS-1:0]); // R12
    if (next_state.special)
      next_state.vclk = i_special_pattern; // R12

    // Horizontal blanking
    if (i_line_start)
    begin
      next_state.blank = 1'b0;
      next_state.in_region = 1'b0;
      next_state.clamp = 1'b0;
      next_state.preblank = 1'b0;
    end
    else if (pulse_mode)
    begin
      // Each repeat is a high phase then a low phase of the set length
      if (i_line_position == low_field(w_bounds))
      begin
        next_state.in_region = pulse_reps != 8'h00; // R07
        next_state.blank = pulse_reps != 8'h00; // R08
        next_state.pulse_count = 13'h0001;
        next_state.pulses_left = pulse_reps; // R08
      end
      else if (i_line_position == high_field(w_bounds))
      begin
        next_state.in_region = 1'b0; // R07
        next_state.blank = 1'b0; // R07
      end
      else if (state.in_region)
      begin
        if (state.pulse_count >= pulse_len)
        begin
          next_state.pulse_count = 13'h0001;
          if (state.blank)
          begin
            next_state.blank = 1'b0; // R08
            next_state.pulses_left = state.pulses_left - 8'h01;
            if (state.pulses_left == 8'h01)
              next_state.in_region = 1'b0; // R08
          end
          else
            next_state.blank = 1'b1; // R08
        end
        else
          next_state.pulse_count = state.pulse_count + 13'h0001;
      end
    end
    else
      next_state.blank = state.blank ^ (^toggle_hit); // R05
    // Two toggles on one position cancel, as the blanking toggles do
    if (!i_line_start)
    begin
      next_state.clamp = state.clamp
        ^ (i_line_position == low_field(w_clamp))
        ^ (i_line_position == high_field(w_clamp)); // R10
      next_state.preblank = state.preblank
        ^ (i_line_position == low_field(w_preblank))
        ^ (i_line_position == high_field(w_preblank)); // R11
    end
    // Masked horizontal clocks follow the new blanking level
    next_state.h1 = next_state.blank
      ? w_len[vsfp_pkg::CLOCK_ONE_MASK_BIT] : i_horiz_clock_one; // R09
    next_state.h3 = next_state.blank
      ? w_len[vsfp_pkg::CLOCK_THREE_MASK_BIT] : i_horiz_clock_three; // R09
    next_state.hl = next_state.blank
      ? w_len[vsfp_pkg::LAST_STAGE_MASK_BIT]
      : i_horiz_last_stage_clock; // R09
  end
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      state <= '0;
      state.sclk_sync <= 2'h3;
      state.sload_sync <= 2'h3;
      state.sclk_last <= 1'b1;
      state.ser_state <= vsfp_pkg::VSFP_SER_IDLE;
      state.staged <= {vsfp_pkg::NUM_REGS{vsfp_pkg::REG_RESET}};
      state.active <= {vsfp_pkg::NUM_REGS{vsfp_pkg::REG_RESET}};
    end
    else
      state <= next_state;
  end
  assign o_vertical_clock_out = state.vclk;
  assign o_horizontal_blanking = state.blank;
  assign o_horiz_clock_one = state.h1;
  assign o_horiz_clock_three = state.h3;
  assign o_horiz_last_stage_clock = state.hl;
  assign o_optical_black_clamp = state.clamp;
  assign o_pre_blanking_pulse = state.preblank;
  assign o_group_a_repeats = state.repeats;
  assign o_vertical_held = state.held;
  assign o_special_pattern_active = state.special;
endmodule

// File: testbench/vsfp_field_params_monitor.sv
// Port checker for the field parameter block
module vsfp_field_params_monitor (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Watched inputs
  input wire logic i_line_start,
  input wire logic i_sequence_change_update,
  input wire logic [1:0] i_group_a_alternation_mode,
  input wire logic i_hold_enable,
  input wire logic [11:0] i_group_a_first_line_repeats,
  input wire logic [12:0] i_vertical_pattern,
  input wire logic [12:0] i_special_pattern,
  input wire logic i_horiz_clock_one,
  input wire logic i_horiz_clock_three,
  input wire logic i_horiz_last_stage_clock,
  // Watched outputs
  input wire logic [12:0] o_vertical_clock_out,
  input wire logic o_horizontal_blanking,
  input wire logic o_horiz_clock_one,
  input wire logic o_horiz_clock_three,
  input wire logic o_horiz_last_stage_clock,
  input wire logic o_optical_black_clamp,
  input wire logic o_pre_blanking_pulse,
  input wire logic [12:0] o_group_a_repeats,
  input wire logic o_vertical_held,
  input wire logic o_special_pattern_active
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);
  // Outputs stay low one edge past release, so skip two edges
  sequence s_settled;
    !$past(i_reset) && !$past(i_reset, 2);
  endsequence
  sequence s_blank_run;
    (o_horizontal_blanking && !i_sequence_change_update) [*2];
  endsequence
  sequence s_held_run;
    (o_vertical_held && !o_special_pattern_active) [*2];
  endsequence
  property p_clock_pass;
    s_settled ##0 !o_horizontal_blanking |->
      o_horiz_clock_one == $past(i_horiz_clock_one) &&
      o_horiz_clock_three == $past(i_horiz_clock_three) &&
      o_horiz_last_stage_clock == $past(i_horiz_last_stage_clock);
  endproperty
  property p_mask_steady;
    s_blank_run ##1 o_horizontal_blanking |-> $stable({o_horiz_clock_one,
      o_horiz_clock_three, o_horiz_last_stage_clock});
  endproperty
  property p_hold_freeze;
    s_held_run |-> $stable(o_vertical_clock_out);
  endproperty
  property p_pattern_pass;
    s_settled ##0 (!o_vertical_held && !$past(o_vertical_held) &&
      !o_special_pattern_active) |->
      o_vertical_clock_out == $past(i_vertical_pattern);
  endproperty
  property p_special;
    o_special_pattern_active |->
      o_vertical_clock_out == $past(i_special_pattern);
  endproperty
  property p_line_clear;
    s_settled ##0 $past(i_line_start) |-> !o_optical_black_clamp &&
      !o_pre_blanking_pulse && !o_horizontal_blanking;
  endproperty
  property p_mode0;
    s_settled ##0 ($past(i_line_start, 2) &&
      $past(i_group_a_alternation_mode) == 2'h0 &&
      $past(i_group_a_alternation_mode, 2) == 2'h0) |->
      o_group_a_repeats == {1'b0, $past(i_group_a_first_line_repeats)};
  endproperty
  property p_hold_needs_enable;
    s_settled ##0 (!$past(i_hold_enable) && !$past(o_vertical_held)) |->
      !o_vertical_held;
  endproperty
  a_clock_pass: assert property (p_clock_pass)
    else $error("clock passed wrongly outside blanking");
  a_mask_steady: assert property (p_mask_steady)
    else $error("masked clock moved during blanking");
  a_hold_freeze: assert property (p_hold_freeze)
    else $error("vertical clocks moved while held");
  a_pattern_pass: assert property (p_pattern_pass)
    else $error("vertical clocks not following pattern");
  a_special: assert property (p_special)
    else $error("special pattern not output");
  a_line_clear: assert property (p_line_clear)
    else $error("line start did not clear pulses");
  a_mode0: assert property (p_mode0)
    else $error("mode zero repeat count wrong");
  a_hold_needs_enable: assert property (p_hold_needs_enable)
    else $error("hold entered while hold disabled");
endmodule

bind vsfp_field_params vsfp_field_params_monitor u_monitor (.*);

// File: testbench/vsfp_ccd_model.sv
// Sensor model counting vertical clock moves while the block holds them
module vsfp_ccd_model (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Drive from the block
  input wire logic [12:0] i_vertical_clock_out,
  input wire logic i_vertical_held,
  input wire logic i_special_pattern_active,
  // Observation
  output logic [12:0] o_moves_while_held
);
  logic [12:0] last;
  logic held_d;
  always_ff @(posedge i_clock)
  begin
    last <= i_vertical_clock_out;
    held_d <= i_vertical_held && !i_special_pattern_active;
    if (i_reset)
      o_moves_while_held <= 13'h0000;
    else if (held_d && i_vertical_held && last != i_vertical_clock_out)
      o_moves_while_held <= o_moves_while_held + 13'h0001;
  end
endmodule

// File: testbench/vsfp_field_params_tb.sv
// Self-checking bench for the field parameter block
module vsfp_field_params_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LINE = 40;
  typedef struct {int cyc; int kind; logic [12:0] exp;} vsfp_note_t;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic i_serial_clock = 1'b0;
  logic i_serial_data = 1'b0;
  logic i_serial_load = 1'b1;
  logic i_line_start = 1'b0;
  logic [12:0] i_line_position = 13'h0000;
  logic [11:0] i_line_number = 12'h000;
  logic i_line_odd = 1'b0;
  logic i_sequence_change_update = 1'b0;
  logic [1:0] i_group_a_alternation_mode = 2'h0;
  logic [2:0] i_blank_alternation_mode = 3'h0;
  logic i_hold_enable = 1'b0;
  logic [11:0] i_group_a_first_line_repeats = 12'h000;
  logic [11:0] i_group_a_second_line_repeats = 12'h000;
  logic [12:0] i_vertical_pattern = 13'h0000;
  logic [12:0] i_special_pattern = 13'h0000;
  logic i_horiz_clock_one = 1'b0;
  logic i_horiz_clock_three = 1'b0;
  logic i_horiz_last_stage_clock = 1'b0;
  logic [12:0] o_vertical_clock_out, o_group_a_repeats, moves_held;
  logic o_horizontal_blanking, o_horiz_clock_one, o_horiz_clock_three;
  logic o_horiz_last_stage_clock, o_optical_black_clamp;
  logic o_pre_blanking_pulse, o_vertical_held, o_special_pattern_active;
  int tog [16];
  int hp [2];
  int rp [2];
  int bstart, bend, blen, brep, lt, cyc, failures, checked, spl, hold_on;
  logic [2:0] mask;
  logic [12:0] rep [4];
  logic hprev;
  vsfp_note_t q [$];
  vsfp_note_t n;

  vsfp_field_params DUT (.*);
  vsfp_ccd_model u_ccd (.i_clock(i_clock), .i_reset(i_reset),
    .i_vertical_clock_out(o_vertical_clock_out),
    .i_vertical_held(o_vertical_held),
    .i_special_pattern_active(o_special_pattern_active),
    .o_moves_while_held(moves_held));

  always #5 i_clock = ~i_clock;
  always @(posedge i_clock) cyc++;

  task cmp_bit(input string what, input logic e, input logic s);
    checked++;
    if (s !== e)
    begin
      failures++;
      $display("mismatch %s expected %b seen %b", what, e, s);
    end
  endtask
  task cmp_vec(input string what, input logic [12:0] e, input logic [12:0] s);
    checked++;
    if (s !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, e, s);
    end
  endtask
  task print_verdict;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  function automatic logic lvl(input int f, input int m, input int p);
    logic v;
    v = 1'b0;
    for (int i = f; i < f + m; i++) v ^= (tog[i] != 0 && tog[i] <= p);
    return v;
  endfunction
  function automatic logic blank_at(input logic odd, input int p);
    int k;
    if (i_blank_alternation_mode < 3'h4) return lvl(odd ? 0 : 6, 6, p);
    if (p < bstart || p >= bend) return 1'b0;
    k = (p - bstart) / blen;
    return k < 2 * brep && k % 2 == 0;
  endfunction

  task note(input int k, input logic [12:0] e);
    q.push_back('{cyc + 1, k, e});
  endtask
  task ser_write(input logic [7:0] a, input logic [25:0] d);
    logic [33:0] f;
    f = {d, a};
    i_serial_load = 1'b0;
    for (int b = 0; b < 34; b++)
    begin
      i_serial_data = f[b];
      repeat (3) @(negedge i_clock);
      i_serial_clock = 1'b1;
      repeat (3) @(negedge i_clock);
      i_serial_clock = 1'b0;
    end
    repeat (3) @(negedge i_clock);
    i_serial_load = 1'b1;
    repeat (6) @(negedge i_clock);
  endtask
  task upd;
    i_sequence_change_update = 1'b1;
    @(negedge i_clock);
    i_sequence_change_update = 1'b0;
  endtask
  task run_line(input logic odd, input int num, input int chk);
    logic [2:0] hin;
    logic h;
    logic sp;
    for (int p = 1; p <= LINE; p++)
    begin
      @(negedge i_clock);
      i_line_start = (p == 1);
      i_line_position = 13'(p);
      i_line_odd = odd;
      i_line_number = 12'(num);
      hin = 3'($urandom);
      {i_horiz_last_stage_clock, i_horiz_clock_three, i_horiz_clock_one} = hin;
      i_vertical_pattern = 13'($urandom);
      i_special_pattern = 13'($urandom);
      if (p == 1) lt = (lt >= i_group_a_alternation_mode) ? 0 : lt + 1;
      if (chk[0]) note(0, {12'h000, blank_at(odd, p)});
      if (chk[0]) note(3, {10'h000, blank_at(odd, p) ? mask : hin});
      if (chk[1]) note(1, {12'h000, lvl(12, 2, p)});
      if (chk[1]) note(2, {12'h000, lvl(14, 2, p)});
      if (chk[3] && p > 2) note(7, rep[lt]);
      h = hold_on && ((p >= hp[0] && p < rp[0]) || (p >= hp[1] && p < rp[1]));
      sp = (num == spl);
      if (chk[2] && !sp) note(4, {12'h000, h});
      if (chk[2]) note(6, {12'h000, sp});
      if (chk[2] && sp) note(5, i_special_pattern);
      else if (chk[2] && !h && !hprev) note(5, i_vertical_pattern);
      hprev = h;
    end
  endtask

  always
  begin
    @(negedge i_clock);
    #1;
    while (q.size() > 0 && q[0].cyc <= cyc)
    begin
      n = q.pop_front();
      case (n.kind)
        0: cmp_bit("blank", n.exp[0], o_horizontal_blanking);
        1: cmp_bit("clamp", n.exp[0], o_optical_black_clamp);
        2: cmp_bit("preblank", n.exp[0], o_pre_blanking_pulse);
        3: cmp_vec("hclocks", n.exp, {10'h000, o_horiz_last_stage_clock,
          o_horiz_clock_three, o_horiz_clock_one});
        4: cmp_bit("held", n.exp[0], o_vertical_held);
        5: cmp_vec("vclock", n.exp, o_vertical_clock_out);
        6: cmp_bit("special", n.exp[0], o_special_pattern_active);
        default: cmp_vec("repeats", n.exp, o_group_a_repeats);
      endcase
    end
  end

  initial
  begin
    repeat (100000) @(posedge i_clock);
    failures++;
    print_verdict;
  end

  initial
  begin
    void'($urandom(72039));
    repeat (16) @(negedge i_clock);
    i_reset = 1'b0;
    @(negedge i_clock);
    // Toggles stay off position 1 so the line start clear is unambiguous
    for (int i = 0; i < 16; i++) tog[i] = 2 + $urandom_range(LINE - 4);
    mask = 3'($urandom);
    ser_write(8'h07, {13'(tog[1]), 13'(tog[0])});
    ser_write(8'h08, {13'(tog[3]), 13'(tog[2])});
    ser_write(8'h09, {13'(tog[5]), 13'(tog[4])});
    ser_write(8'h0A, {13'(tog[7]), 13'(tog[6])});
    ser_write(8'h0B, {13'(tog[9]), 13'(tog[8])});
    ser_write(8'h0C, {13'(tog[11]), 13'(tog[10])});
    ser_write(8'h0D, {2'h0, mask, 21'h000000});
    ser_write(8'h0E, {13'(tog[13]), 13'(tog[12])});
    ser_write(8'h0F, {13'(tog[15]), 13'(tog[14])});
    ser_write(8'h10, 26'h0000000);
    ser_write(8'h12, 26'h0000000);
    ser_write(8'h13, 26'h0000000);
    ser_write(8'h14, 26'h3FFFFFF);
    upd;
    i_blank_alternation_mode = 3'($urandom_range(3));
    run_line(1'b1, 0, 3);
    run_line(1'b0, 1, 3);
    ser_write(8'h0E, {13'(tog[13] + 1), 13'(tog[12] + 1)});
    run_line(1'b1, 2, 2);
    upd;
    tog[12]++;
    tog[13]++;
    run_line(1'b0, 3, 2);
    for (int m = 4; m < 8; m++)
    begin
      bstart = 2 + $urandom_range(5);
      blen = 1 + $urandom_range(3);
      brep = $urandom_range(3);
      bend = bstart + 1 + $urandom_range(31);
      ser_write(8'h0C, {13'(bend), 13'(bstart)});
      ser_write(8'h0D, {2'h0, mask, 8'(brep), 13'(blen)});
      upd;
      i_blank_alternation_mode = 3'(m);
      run_line(1'(m), m, 1);
    end
    i_blank_alternation_mode = 3'h0;
    i_group_a_first_line_repeats = 12'($urandom);
    i_group_a_second_line_repeats = 12'($urandom);
    rep[0] = {1'b0, i_group_a_first_line_repeats};
    rep[1] = {1'b0, i_group_a_second_line_repeats};
    rep[2] = 13'(2 + $urandom_range(LINE - 4));
    rep[3] = 13'(2 + $urandom_range(LINE - 4));
    tog[10] = bstart;
    tog[11] = bend;
    ser_write(8'h07, {rep[3], rep[2]});
    upd;
    for (int m = 0; m < 4; m++)
    begin
      i_group_a_alternation_mode = 2'(m);
      // Odd lines see the repeat fields as toggles only while uncycled
      tog[0] = (m < 2) ? int'(rep[2]) : 0;
      tog[1] = (m < 3) ? int'(rep[3]) : 0;
      for (int k = 0; k < 5; k++) run_line(1'(k), 0, 9);
    end
    i_group_a_alternation_mode = 2'h0;
    hp[0] = 2 + $urandom_range(8);
    rp[0] = hp[0] + 1 + $urandom_range(8);
    hp[1] = 20 + $urandom_range(5);
    rp[1] = hp[1] + 1 + $urandom_range(10);
    spl = 100 + $urandom_range(3000);
    ser_write(8'h08, {13'(rp[0]), 13'(hp[0])});
    ser_write(8'h09, {13'(rp[1]), 13'(hp[1])});
    ser_write(8'h11, {12'h000, 1'b1, 1'b0, 12'(spl)});
    upd;
    i_hold_enable = 1'b1;
    hold_on = 1;
    run_line(1'b1, spl + 1, 4);
    run_line(1'b0, spl, 4);
    i_hold_enable = 1'b0;
    hold_on = 0;
    run_line(1'b1, spl + 1, 4);
    cmp_vec("moves_held", 13'h0000, moves_held);
    repeat (2) @(negedge i_clock);
    print_verdict;
  end
endmodule
